// ---- include/satg_regs.svh ----
// Register offsets, field positions, reset values and timing counts for the servo auxiliary block.
`ifndef SATG_REGS_SVH
`define SATG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SATG_OFF_CTRL      12'h000
`define SATG_OFF_FFGAIN    12'h004
`define SATG_OFF_SPDTHR    12'h008
`define SATG_OFF_JOG       12'h00C
`define SATG_OFF_G3DLY     12'h010
`define SATG_OFF_G3SCL     12'h014
`define SATG_OFF_TOFS      12'h018
`define SATG_OFF_FWDF      12'h01C
`define SATG_OFF_REVF      12'h020
`define SATG_OFF_FEXP      12'h024
`define SATG_OFF_STATUS    12'h028
`define SATG_OFF_IRQ_STAT  12'h02C
`define SATG_OFF_IRQ_MASK  12'h030
`define SATG_OFF_FIXED     12'h034

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SATG_CTRL_REGEN_BIT 0
`define SATG_CTRL_LOCK_BIT  1
`define SATG_FEXP_AFF_BIT   5
`define SATG_IRQ_REGEN_BIT  0
`define SATG_IRQ_SPD_BIT    1

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define SATG_RST_JOG       16'h012C
`define SATG_RST_G3SCL     16'h0064
`define SATG_RST_FIXED     16'h0004
`define SATG_FF_GAIN_MIN   16'h000A
`define SATG_FF_GAIN_MAX   16'h0064
`define SATG_SPD_THR_MAX   16'h0064
`define SATG_JOG_MAX       16'h01F4
`define SATG_G3DLY_MAX     16'h2710
`define SATG_G3SCL_MIN     16'h0032
`define SATG_G3SCL_MAX     16'h03E8
`define SATG_COMP_LIM      16'h0064

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SATG_CLK_HZ        10000000
`define SATG_DLY_STEP_US   100
`define SATG_DLY_STEP_CYC  ((`SATG_CLK_HZ / 1000000) * `SATG_DLY_STEP_US)

`endif

// ---- include/satg_pkg.sv ----
// Types shared by the servo auxiliary block.
package satg_pkg;
	typedef enum logic [1:0] {
		SATG_MODE_POS = 2'h0,
		SATG_MODE_VEL = 2'h1,
		SATG_MODE_TRQ = 2'h3,
		SATG_MODE_FCL = 2'h2
	} satg_mode_t;

	typedef enum logic [1:0] {
		SATG_G3_IDLE = 2'h0,
		SATG_G3_WAIT = 2'h1,
		SATG_G3_ON = 2'h3
	} satg_g3_state_t;
endpackage

// ---- hw/satg_gain3_timer.sv ----
// Third position gain delay timer and gain scaling.
`timescale 1ns/10ps
`include "satg_regs.svh"
module satg_gain3_timer #(
	parameter int STEP_CYC = `SATG_DLY_STEP_CYC
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic allowed_i,
	input wire logic [15:0] delay_i,
	input wire logic [15:0] scale_i,
	input wire logic [15:0] gain1_i,
	output logic active_o,
	output logic [15:0] gain_o
);
	satg_pkg::satg_g3_state_t state;
	satg_pkg::satg_g3_state_t next_state;
	logic [15:0] step_cnt;
	logic [15:0] tick_cnt;
	logic [31:0] prod;
	logic [31:0] quot;
	wire tick = (step_cnt == 16'(STEP_CYC - 1));
	wire expired = (tick_cnt >= delay_i);

	// ----------------------------------------------------------------
	// Delay sequencing
	// ----------------------------------------------------------------
	always_comb begin
		case (state)
			satg_pkg::SATG_G3_IDLE: next_state = start_i ? satg_pkg::SATG_G3_WAIT : state;
			satg_pkg::SATG_G3_WAIT: next_state = expired ? satg_pkg::SATG_G3_ON : state;
			satg_pkg::SATG_G3_ON: next_state = state;
			default: next_state = satg_pkg::SATG_G3_IDLE;
		endcase
		if (!allowed_i) begin
			next_state = satg_pkg::SATG_G3_IDLE;
		end
	end

	// The timer counts in 0.1 ms steps, once per control tick.
	always_ff @(posedge core_clk_i) begin
		if (srst_i || state != satg_pkg::SATG_G3_WAIT) begin
			step_cnt <= 16'h0000;
			tick_cnt <= 16'h0000;
		end else if (tick) begin
			step_cnt <= 16'h0000;
			tick_cnt <= tick_cnt + 16'h0001;
		end else begin
			step_cnt <= step_cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= satg_pkg::SATG_G3_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Gain scaling
	// ----------------------------------------------------------------
	assign prod = 32'(gain1_i) * 32'(scale_i);
	assign quot = prod / 32'd100;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			active_o <= 1'b0;
			gain_o <= 16'h0000;
		end else begin
			active_o <= (state == satg_pkg::SATG_G3_ON);
			gain_o <= (state == satg_pkg::SATG_G3_ON) ? quot[15:0] : gain1_i;
		end
	end
endmodule // satg_gain3_timer

// ---- hw/satg_aux_logic.sv ----
// Servo auxiliary logic: protections, panel lock, torque additions and third gain, APB slave.
//
// Functional notes
// - Regen limit error raised only when enabled.
// - Panel lock refuses front-panel operations.
// - Power-cycle settings apply only after reset; a reset longer than one edge here clears them to 0 instead.
// - Feed-forward gain 0 to 9 gives none.
// - Feed-forward active only with expansion bit 5.
// - Analog input 3 in use disables feed-forward.
// - Torque equals 100 times volts over gain/10.
// - Speed deviation above threshold raises error.
// - JOG uses velocity mode at set speed.
// - Third gain valid after delay set in 0.1 ms units.
// - Third gain is first gain times scale/100.
// - Third gain only in position/full-closed modes.
// - Torque offset added except torque control.
// - Forward friction added on forward command.
// - Reverse friction added on reverse command.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "satg_regs.svh"
module satg_aux_logic #(
	parameter int STEP_CYC = `SATG_DLY_STEP_CYC
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] ctrl_mode_i,
	input wire logic jog_i,
	input wire logic ain3_busy_i,
	input wire logic signed [15:0] ain3_mv_i,
	input wire logic signed [15:0] torque_cmd_i,
	input wire logic signed [15:0] cmd_speed_i,
	input wire logic signed [15:0] act_speed_i,
	input wire logic fwd_cmd_i,
	input wire logic rev_cmd_i,
	input wire logic regen_over_i,
	input wire logic [15:0] gain1_i,
	input wire logic panel_req_i,
	output logic panel_grant_o,
	output logic signed [15:0] torque_out_o,
	output logic [1:0] eff_mode_o,
	output logic signed [15:0] vel_cmd_o,
	output logic [15:0] pos_gain_o,
	output logic gain3_active_o,
	output logic regen_pulse_limit_error_o,
	output logic speed_overdeviation_error_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	logic regen_limit_enable_setting;
	logic panel_lock_setting;
	logic live_regen_en;
	logic live_lock;
	logic [15:0] analog_ff_gain_setting;
	logic [15:0] speed_deviation_threshold;
	logic [15:0] jog_speed_setting;
	logic [15:0] third_gain_delay_setting;
	logic [15:0] third_gain_scale_setting;
	logic [15:0] torque_offset_setting;
	logic [15:0] fwd_friction_comp_setting;
	logic [15:0] rev_friction_comp_setting;
	logic [5:0] function_expansion_bits;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic mode_ok_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire wr_en = psel && penable && pwrite;
	// Read data is captured in the setup cycle so that it already stands at the access edge.
	wire rd_setup = psel && !penable && !pwrite;
	wire [15:0] wd = pwdata[15:0];
	wire hit_ctrl = (paddr == `SATG_OFF_CTRL);
	wire hit_ffg = (paddr == `SATG_OFF_FFGAIN);
	wire hit_thr = (paddr == `SATG_OFF_SPDTHR);
	wire hit_jog = (paddr == `SATG_OFF_JOG);
	wire hit_g3d = (paddr == `SATG_OFF_G3DLY);
	wire hit_g3s = (paddr == `SATG_OFF_G3SCL);
	wire hit_tofs = (paddr == `SATG_OFF_TOFS);
	wire hit_fwd = (paddr == `SATG_OFF_FWDF);
	wire hit_rev = (paddr == `SATG_OFF_REVF);
	wire hit_fexp = (paddr == `SATG_OFF_FEXP);
	wire hit_stat = (paddr == `SATG_OFF_STATUS);
	wire hit_ist = (paddr == `SATG_OFF_IRQ_STAT);
	wire hit_imsk = (paddr == `SATG_OFF_IRQ_MASK);
	wire hit_fix = (paddr == `SATG_OFF_FIXED);
	wire hit_any = hit_ctrl | hit_ffg | hit_thr | hit_jog | hit_g3d | hit_g3s | hit_tofs
		| hit_fwd | hit_rev | hit_fexp | hit_stat | hit_ist | hit_imsk | hit_fix;

	// Out-of-range writes are refused with an error so a setting never leaves its range.
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic comp_ok(input logic [15:0] v);
		comp_ok = ($signed(v) >= -$signed(`SATG_COMP_LIM)) && ($signed(v) <= $signed(`SATG_COMP_LIM));
	endfunction

	wire range_bad = (hit_ffg && !in_range(wd, 16'h0000, `SATG_FF_GAIN_MAX))
		|| (hit_thr && !in_range(wd, 16'h0000, `SATG_SPD_THR_MAX))
		|| (hit_jog && !in_range(wd, 16'h0000, `SATG_JOG_MAX))
		|| (hit_g3d && !in_range(wd, 16'h0000, `SATG_G3DLY_MAX))
		|| (hit_g3s && !in_range(wd, `SATG_G3SCL_MIN, `SATG_G3SCL_MAX))
		|| ((hit_tofs || hit_fwd || hit_rev) && !comp_ok(wd));
	wire wr_ok = wr_en && hit_any && !(pwrite && range_bad);

	assign pready = 1'b1;
	assign pslverr = psel && penable && (!hit_any || (pwrite && range_bad));

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			regen_limit_enable_setting <= 1'b0;
			panel_lock_setting <= 1'b0;
			analog_ff_gain_setting <= 16'h0000;
			speed_deviation_threshold <= 16'h0000;
			jog_speed_setting <= `SATG_RST_JOG;
			third_gain_delay_setting <= 16'h0000;
			third_gain_scale_setting <= `SATG_RST_G3SCL;
			torque_offset_setting <= 16'h0000;
			fwd_friction_comp_setting <= 16'h0000;
			rev_friction_comp_setting <= 16'h0000;
			function_expansion_bits <= 6'h00;
			irq_mask <= 2'h0;
		end else if (wr_ok) begin
			if (hit_ctrl) begin
				regen_limit_enable_setting <= wd[`SATG_CTRL_REGEN_BIT];
				panel_lock_setting <= wd[`SATG_CTRL_LOCK_BIT];
			end
			if (hit_ffg) analog_ff_gain_setting <= wd;
			if (hit_thr) speed_deviation_threshold <= wd;
			if (hit_jog) jog_speed_setting <= wd;
			if (hit_g3d) third_gain_delay_setting <= wd;
			if (hit_g3s) third_gain_scale_setting <= wd;
			if (hit_tofs) torque_offset_setting <= wd;
			if (hit_fwd) fwd_friction_comp_setting <= wd;
			if (hit_rev) rev_friction_comp_setting <= wd;
			if (hit_fexp) function_expansion_bits <= wd[5:0];
			if (hit_imsk) irq_mask <= wd[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Power-cycle settings
	// ----------------------------------------------------------------
	// Control-power reset stands for power-on; the first reset edge takes the stored value, which that edge clears, so a longer reset takes 0.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			live_regen_en <= regen_limit_enable_setting;
			live_lock <= panel_lock_setting;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	wire [31:0] rd_mux =
		hit_ctrl ? {30'h0, panel_lock_setting, regen_limit_enable_setting} :
		hit_ffg ? {16'h0, analog_ff_gain_setting} :
		hit_thr ? {16'h0, speed_deviation_threshold} :
		hit_jog ? {16'h0, jog_speed_setting} :
		hit_g3d ? {16'h0, third_gain_delay_setting} :
		hit_g3s ? {16'h0, third_gain_scale_setting} :
		hit_tofs ? {16'h0, torque_offset_setting} :
		hit_fwd ? {16'h0, fwd_friction_comp_setting} :
		hit_rev ? {16'h0, rev_friction_comp_setting} :
		hit_fexp ? {26'h0, function_expansion_bits} :
		hit_stat ? {27'h0, gain3_active_o, live_lock, live_regen_en,
			speed_overdeviation_error_o, regen_pulse_limit_error_o} :
		hit_ist ? {30'h0, irq_stat} :
		hit_imsk ? {30'h0, irq_mask} :
		hit_fix ? {16'h0, `SATG_RST_FIXED} : 32'h0;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Protections
	// ----------------------------------------------------------------
	wire signed [16:0] spd_dev = 17'(cmd_speed_i) - 17'(act_speed_i);
	wire spd_trip = (speed_deviation_threshold != 16'h0000)
		&& (spd_dev > $signed({1'b0, speed_deviation_threshold}));
	wire regen_trip = live_regen_en && regen_over_i;
	wire [1:0] ev = {spd_trip, regen_trip};
	wire ist_clr = wr_en && hit_ist;

	// Errors latch until the next control-power reset; interrupt status is write-one-clear.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			regen_pulse_limit_error_o <= 1'b0;
			speed_overdeviation_error_o <= 1'b0;
			irq_stat <= 2'h0;
		end else begin
			regen_pulse_limit_error_o <= regen_pulse_limit_error_o | regen_trip;
			speed_overdeviation_error_o <= speed_overdeviation_error_o | spd_trip;
			irq_stat <= (irq_stat & ~(ist_clr ? wd[1:0] : 2'h0)) | ev;
		end
	end

	assign irq_o = |(irq_stat & irq_mask);
	assign panel_grant_o = panel_req_i && !live_lock;

	// ----------------------------------------------------------------
	// Torque command additions
	// ----------------------------------------------------------------
	wire ff_on = function_expansion_bits[`SATG_FEXP_AFF_BIT]
		&& !ain3_busy_i
		&& (analog_ff_gain_setting >= `SATG_FF_GAIN_MIN);
	// Millivolts over gain in 0.1 V gives percent directly; sign keeps CCW positive.
	wire signed [31:0] ff_num = 32'(ain3_mv_i);
	wire signed [31:0] ff_den = $signed({16'h0, ff_on ? analog_ff_gain_setting : 16'h0001});
	wire signed [31:0] ff_pct = ff_on ? ff_num / ff_den : 32'sh0;
	wire not_trq = (eff_mode_o != 2'(satg_pkg::SATG_MODE_TRQ));
	wire signed [31:0] ofs = not_trq ? 32'($signed(torque_offset_setting)) : 32'sh0;
	wire signed [31:0] fwdc = fwd_cmd_i ? 32'($signed(fwd_friction_comp_setting)) : 32'sh0;
	wire signed [31:0] revc = rev_cmd_i ? 32'($signed(rev_friction_comp_setting)) : 32'sh0;
	wire signed [31:0] tsum = 32'(torque_cmd_i) + ff_pct + ofs + fwdc + revc;
	wire signed [15:0] tsat = (tsum > 32'sh7FFF) ? 16'sh7FFF :
		(tsum < -32'sh8000) ? -16'sh8000 : tsum[15:0];

	// ----------------------------------------------------------------
	// Mode, JOG speed
	// ----------------------------------------------------------------
	wire [1:0] next_mode = jog_i ? 2'(satg_pkg::SATG_MODE_VEL) : ctrl_mode_i;
	wire mode_ok = (next_mode == 2'(satg_pkg::SATG_MODE_POS))
		|| (next_mode == 2'(satg_pkg::SATG_MODE_FCL));

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			eff_mode_o <= 2'(satg_pkg::SATG_MODE_POS);
			vel_cmd_o <= 16'sh0000;
			torque_out_o <= 16'sh0000;
			mode_ok_q <= 1'b0;
		end else begin
			eff_mode_o <= next_mode;
			vel_cmd_o <= jog_i ? $signed(jog_speed_setting) : 16'sh0000;
			torque_out_o <= tsat;
			mode_ok_q <= mode_ok;
		end
	end

	// ----------------------------------------------------------------
	// Third gain
	// ----------------------------------------------------------------
	// Software keeps delay 0 and scale 100 when unused, which leaves the first gain unchanged.
	satg_gain3_timer #(
		.STEP_CYC(STEP_CYC)
	) u_gain3 (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.start_i(mode_ok_q),
		.allowed_i(mode_ok),
		.delay_i(third_gain_delay_setting),
		.scale_i(third_gain_scale_setting),
		.gain1_i(gain1_i),
		.active_o(gain3_active_o),
		.gain_o(pos_gain_o)
	);
endmodule // satg_aux_logic

// ---- verif/satg_aux_checker.sv ----
// Port checker for the servo auxiliary block.
`timescale 1ns/10ps
module satg_aux_checker #(
	parameter int STEP_CYC = 1000
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [1:0] ctrl_mode_i,
	input wire logic jog_i,
	input wire logic signed [15:0] cmd_speed_i,
	input wire logic signed [15:0] act_speed_i,
	input wire logic regen_over_i,
	input wire logic panel_req_i,
	input wire logic panel_grant_o,
	input wire logic [1:0] eff_mode_o,
	input wire logic gain3_active_o,
	input wire logic regen_pulse_limit_error_o,
	input wire logic speed_overdeviation_error_o,
	input wire logic irq_o
);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Widened so that a large reverse speed cannot wrap into a positive deviation.
	wire logic signed [16:0] dv = {cmd_speed_i[15], cmd_speed_i} - {act_speed_i[15], act_speed_i};
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	regen_latch_a: assert property (regen_pulse_limit_error_o |=> regen_pulse_limit_error_o)
		else $error("regen error dropped without reset");
	reset_clear_a: assert property ($fell(srst_i) |-> !irq_o && !gain3_active_o
		&& !regen_pulse_limit_error_o && !speed_overdeviation_error_o)
		else $error("outputs not cleared by reset");
	spd_rise_a: assert property ($rose(speed_overdeviation_error_o) |-> $past(dv) > 17'sh1)
		else $error("speed error without deviation");
	regen_rise_a: assert property ($rose(regen_pulse_limit_error_o) |-> $past(regen_over_i))
		else $error("regen error without condition");
	panel_gate_a: assert property (panel_grant_o |-> panel_req_i)
		else $error("panel grant without request");
	jog_mode_a: assert property (jog_i |=> eff_mode_o == 2'h1)
		else $error("jog did not force velocity mode");
	g3_leave_a: assert property (ctrl_mode_i[0] |-> ##[1:2] !gain3_active_o)
		else $error("third gain held outside position modes");
	irq_cause_a: assert property (irq_o |-> regen_pulse_limit_error_o || speed_overdeviation_error_o)
		else $error("interrupt without latched error");
endmodule // satg_aux_checker

// ---- verif/satg_motor_model.sv ----
// Behavioural motor, encoder and host speed command source.
`timescale 1ns/10ps
module satg_motor_model (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic signed [15:0] host_spd_i,
	input wire logic signed [15:0] lag_i,
	input wire logic regen_fault_i,
	output logic signed [15:0] cmd_speed_o,
	output logic signed [15:0] act_speed_o,
	output logic fwd_cmd_o,
	output logic rev_cmd_o,
	output logic regen_over_o
);
	// The shaft trails the command by lag_i, which the bench changes; load noise is not modelled.
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cmd_speed_o <= 16'sh0000;
			act_speed_o <= 16'sh0000;
			fwd_cmd_o <= 1'b0;
			rev_cmd_o <= 1'b0;
			regen_over_o <= 1'b0;
		end else begin
			cmd_speed_o <= host_spd_i;
			act_speed_o <= host_spd_i - lag_i;
			fwd_cmd_o <= host_spd_i > 16'sh0000;
			rev_cmd_o <= host_spd_i < 16'sh0000;
			regen_over_o <= regen_fault_i;
		end
	end
endmodule // satg_motor_model

// ---- verif/test_satg_aux_logic.sv ----
// Self-checking bench for the servo auxiliary block.
`timescale 1ns/10ps
`include "satg_regs.svh"
module test_satg_aux_logic;
	localparam int STEP = 2;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, jog_i = 1'b0, ain3_busy_i = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, panel_req_i = 1'b0, regen_fault = 1'b0;
	logic [1:0] ctrl_mode_i = 2'h0, eff_mode_o;
	logic signed [15:0] ain3_mv_i = 16'sh0, torque_cmd_i = 16'sh0, host_spd = 16'sh0, lag = 16'sh0;
	logic signed [15:0] cmd_speed_i, act_speed_i, torque_out_o, vel_cmd_o;
	logic fwd_cmd_i, rev_cmd_i, regen_over_i, panel_grant_o, gain3_active_o, irq_o;
	logic regen_pulse_limit_error_o, speed_overdeviation_error_o;
	logic [15:0] gain1_i = 16'h00C8, pos_gain_o;
	int failures = 0, checks_done = 0, cyc = 0;
	logic [11:0] tb_a[5] = '{`SATG_OFF_JOG, `SATG_OFF_G3SCL, `SATG_OFF_FFGAIN, `SATG_OFF_G3DLY,
		`SATG_OFF_SPDTHR};
	logic [31:0] bad_d[5] = '{32'h1F5, 32'h31, 32'h65, 32'h2711, 32'h65};
	logic [31:0] rst_d[5] = '{32'h12C, 32'h64, 32'h0, 32'h0, 32'h0};
	always #50 core_clk_i = ~core_clk_i;
	satg_aux_logic #(.STEP_CYC(STEP)) i_satg_aux_logic (.core_clk_i, .srst_i, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_mode_i, .jog_i, .ain3_busy_i,
		.ain3_mv_i, .torque_cmd_i, .cmd_speed_i, .act_speed_i, .fwd_cmd_i, .rev_cmd_i, .regen_over_i,
		.gain1_i, .panel_req_i, .panel_grant_o, .torque_out_o, .eff_mode_o, .vel_cmd_o, .pos_gain_o,
		.gain3_active_o, .regen_pulse_limit_error_o, .speed_overdeviation_error_o, .irq_o);
	satg_motor_model i_satg_motor_model (.core_clk_i, .srst_i, .host_spd_i(host_spd), .lag_i(lag),
		.regen_fault_i(regen_fault), .cmd_speed_o(cmd_speed_i), .act_speed_o(act_speed_i),
		.fwd_cmd_o(fwd_cmd_i), .rev_cmd_o(rev_cmd_i), .regen_over_o(regen_over_i));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks_done=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	// The access phase lasts until pready; only the bench watchdog ends a wait.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		w(1);
		penable <= 1'b1;
		w(1);
		while (pready !== 1'b1) begin
			w(1);
		end
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		w(1);
	endtask
	task automatic tq(input logic signed [15:0] e);
		w(4);
		chk(torque_out_o, e);
	endtask
	task automatic rst(input int n);
		srst_i <= 1'b1;
		w(n);
		srst_i <= 1'b0;
		w(1);
	endtask
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		rst(6);
		apb(1'b0, 12'h038, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b0, `SATG_OFF_FIXED, 32'h0);
		chk(rd, 32'h4);
		foreach (tb_a[i]) begin
			apb(1'b1, tb_a[i], bad_d[i]);
			chk(err, 1'b1);
			apb(1'b0, tb_a[i], 32'h0);
			chk(rd, rst_d[i]);
		end
		apb(1'b1, `SATG_OFF_TOFS, 32'h5);
		apb(1'b1, `SATG_OFF_FWDF, 32'h3);
		apb(1'b1, `SATG_OFF_REVF, 32'hFFFC);
		torque_cmd_i <= 16'sh000A;
		host_spd <= 16'sh0064;
		tq(16'sh0012);
		host_spd <= -16'sh0064;
		tq(16'sh000B);
		ctrl_mode_i <= 2'h3;
		tq(16'sh0006);
		host_spd <= 16'sh0000;
		ctrl_mode_i <= 2'h1;
		apb(1'b1, `SATG_OFF_FFGAIN, 32'h14);
		apb(1'b1, `SATG_OFF_FEXP, 32'h1F);
		ain3_mv_i <= 16'sh03E8;
		tq(16'sh000F);
		apb(1'b1, `SATG_OFF_FEXP, 32'h20);
		tq(16'sh0041);
		ain3_mv_i <= -16'sh03E8;
		tq(-16'sh0023);
		ain3_busy_i <= 1'b1;
		tq(16'sh000F);
		ain3_busy_i <= 1'b0;
		apb(1'b1, `SATG_OFF_FFGAIN, 32'h9);
		tq(16'sh000F);
		apb(1'b1, `SATG_OFF_FFGAIN, 32'hA);
		tq(-16'sh0055);
		host_spd <= 16'sh00C8;
		lag <= 16'sh00C8;
		w(4);
		chk(speed_overdeviation_error_o, 1'b0);
		lag <= 16'sh0064;
		w(3);
		apb(1'b1, `SATG_OFF_SPDTHR, 32'h64);
		w(4);
		chk(speed_overdeviation_error_o, 1'b0);
		lag <= 16'sh0065;
		w(4);
		chk({irq_o, speed_overdeviation_error_o}, 32'h1);
		lag <= 16'sh0000;
		apb(1'b0, `SATG_OFF_IRQ_STAT, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, `SATG_OFF_IRQ_MASK, 32'h2);
		chk(irq_o, 1'b1);
		apb(1'b1, `SATG_OFF_IRQ_STAT, 32'h2);
		chk({irq_o, speed_overdeviation_error_o}, 32'h1);
		ctrl_mode_i <= 2'h1;
		jog_i <= 1'b1;
		w(3);
		chk(vel_cmd_o, 16'sh012C);
		apb(1'b1, `SATG_OFF_JOG, 32'h1F4);
		w(2);
		chk({eff_mode_o, vel_cmd_o}, {2'h1, 16'sh01F4});
		jog_i <= 1'b0;
		apb(1'b1, `SATG_OFF_G3SCL, 32'h3E8);
		apb(1'b1, `SATG_OFF_G3DLY, 32'hA);
		chk({gain3_active_o, pos_gain_o}, 32'h00C8);
		ctrl_mode_i <= 2'h0;
		w(10);
		chk(gain3_active_o, 1'b0);
		w(20);
		chk({gain3_active_o, pos_gain_o}, 32'h107D0);
		ctrl_mode_i <= 2'h3;
		w(3);
		chk({gain3_active_o, pos_gain_o}, 32'h00C8);
		ctrl_mode_i <= 2'h2;
		w(35);
		chk(gain3_active_o, 1'b1);
		apb(1'b1, `SATG_OFF_G3DLY, 32'h0);
		apb(1'b1, `SATG_OFF_G3SCL, 32'h64);
		w(4);
		chk(pos_gain_o, 16'h00C8);
		regen_fault <= 1'b1;
		panel_req_i <= 1'b1;
		apb(1'b1, `SATG_OFF_CTRL, 32'h3);
		w(4);
		chk({panel_grant_o, regen_pulse_limit_error_o}, 32'h2);
		// A one-edge reset carries the stored power-cycle bits into their live copies.
		rst(1);
		w(4);
		chk({panel_grant_o, regen_pulse_limit_error_o}, 32'h1);
		apb(1'b0, `SATG_OFF_STATUS, 32'h0);
		chk(rd, 32'h1D);
		apb(1'b0, `SATG_OFF_IRQ_STAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, `SATG_OFF_IRQ_MASK, 32'h1);
		apb(1'b1, `SATG_OFF_IRQ_STAT, 32'h1);
		chk(irq_o, 1'b1);
		rst(6);
		w(4);
		chk({panel_grant_o, regen_pulse_limit_error_o}, 32'h2);
		tally_and_finish();
	end
endmodule // test_satg_aux_logic
bind satg_aux_logic satg_aux_checker #(.STEP_CYC(STEP_CYC)) i_satg_aux_checker (.core_clk_i,
	.srst_i, .ctrl_mode_i, .jog_i, .cmd_speed_i, .act_speed_i, .regen_over_i, .panel_req_i,
	.panel_grant_o, .eff_mode_o, .gain3_active_o, .regen_pulse_limit_error_o,
	.speed_overdeviation_error_o, .irq_o);
